// File: inc/asr_pkg.sv
// Purpose: constants for the static memory host controller
// Assumes: 10 MHz system clock, one pin update per clock edge
// Notes: times in ns; cycle counts derived from the clock period
package asr_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int DEPTH_WORDS = 131072;
  // fast grade figures; slow grade uses the second set
  localparam int READ_CYCLE_MIN_FAST_NS = 70;
  localparam int READ_CYCLE_MIN_SLOW_NS = 85;
  localparam int ADDRESS_TO_DATA_DELAY_FAST_NS = 70;
  localparam int ADDRESS_TO_DATA_DELAY_SLOW_NS = 85;
  localparam int WRITE_PULSE_MIN_FAST_NS = 50;
  localparam int WRITE_PULSE_MIN_SLOW_NS = 60;
  localparam int ADDR_TO_WRITE_END_SLOW_NS = 75;
  localparam int WRITE_DATA_SETUP_SLOW_NS = 30;
  localparam int WRITE_RECOVERY_NS = 10;
  localparam int FLOAT_DELAY_NS = 25;
  localparam int WRITE_TO_FLOAT_DELAY_SLOW_NS = 30;
  // least times round up, never below one cycle
  function automatic int asr_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : asr_cycles
  // slow-grade figures cover both grades
  localparam int READ_WAIT_CYC = asr_cycles(ADDRESS_TO_DATA_DELAY_SLOW_NS);
  localparam int WRITE_PULSE_CYC = asr_cycles(ADDR_TO_WRITE_END_SLOW_NS);
  localparam int RECOVERY_CYC = asr_cycles(WRITE_RECOVERY_NS);
  localparam int TURN_CYC = asr_cycles(WRITE_TO_FLOAT_DELAY_SLOW_NS);
  localparam int RETAIN_WAIT_CYC = asr_cycles(READ_CYCLE_MIN_SLOW_NS);
  localparam int CNT_W = 4;
  typedef enum logic [2:0] {
    ASR_IDLE = 3'b000,
    ASR_SETUP = 3'b001,
    ASR_ACTIVE = 3'b011,
    ASR_RECOVER = 3'b010,
    ASR_TURN = 3'b110,
    ASR_RETAIN = 3'b111,
    ASR_WAKE = 3'b101
  } asr_state_t;
endpackage : asr_pkg

// File: src/asr_delay_counter.sv
// Purpose: down counter that times one controller phase
// Assumes: load and count never asserted together with meaning
// Notes: done is high while the count is zero
`timescale 1ns/1ps
module asr_delay_counter #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] load_value_in,
  output logic done_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // load wins over counting so a phase always starts full
  always_comb begin
    next_count = count;
    if (load_in) begin
      next_count = load_value_in;
    end else if (count != '0) begin
      next_count = count - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done_out = (count == '0);
endmodule : asr_delay_counter

// File: src/asr_host.sv
// Purpose: host controller driving an asynchronous 128k x 8 static memory
// Assumes: memory pins sampled synchronously to clk_in, no memory clock
// Notes: one request at a time; pin timing spans whole 100 ns cycles
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
#(
  parameter int ADDR_WIDTH = asr_pkg::ADDR_W,
  parameter int DATA_WIDTH = asr_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_WIDTH-1:0] req_addr_in,
  input wire logic [DATA_WIDTH-1:0] req_wdata_in,
  input wire logic retain_req_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_WIDTH-1:0] rd_data_out,
  output logic retained_out,
  output logic [ADDR_WIDTH-1:0] word_address_out,
  output logic select_active_low_n_out,
  output logic select_active_high_out,
  output logic write_strobe_n_out,
  output logic drive_enable_n_out,
  input wire logic [DATA_WIDTH-1:0] shared_data_bus_in,
  output logic [DATA_WIDTH-1:0] shared_data_bus_out,
  output logic shared_data_bus_oe_out
);
  import asr_pkg::*;

  asr_state_t state;
  asr_state_t next_state;
  logic is_write;
  logic next_is_write;
  logic [ADDR_WIDTH-1:0] addr;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [DATA_WIDTH-1:0] wdata;
  logic [DATA_WIDTH-1:0] next_wdata;
  logic [DATA_WIDTH-1:0] rdata;
  logic [DATA_WIDTH-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic sel_n;
  logic next_sel_n;
  logic sel_h;
  logic next_sel_h;
  logic we_n;
  logic next_we_n;
  logic oe_n;
  logic next_oe_n;
  logic bus_oe;
  logic next_bus_oe;
  logic cnt_load;
  logic [CNT_W-1:0] cnt_value;
  logic cnt_done;

  // phase timer shared by all waits
  asr_delay_counter #(
    .WIDTH(CNT_W)
  ) u_timer (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .load_in(cnt_load),
    .load_value_in(cnt_value),
    .done_out(cnt_done)
  );

  // sequencing of pins; address is set a cycle before any strobe
  always_comb begin
    next_state = state;
    next_is_write = is_write;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_sel_n = sel_n;
    next_sel_h = sel_h;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_bus_oe = bus_oe;
    cnt_load = 1'b0;
    cnt_value = '0;
    case (state)
      ASR_IDLE: begin
        if (retain_req_in) begin
          // deselect first, supply may then drop
          next_sel_n = 1'b1;
          next_sel_h = 1'b0;
          next_state = ASR_RETAIN;
        end else if (req_valid_in) begin
          next_addr = req_addr_in; // address before select
          next_wdata = req_wdata_in;
          next_is_write = req_write_in;
          next_state = ASR_SETUP;
        end
      end
      ASR_SETUP: begin
        // both selects active together
        next_sel_n = 1'b0;
        next_sel_h = 1'b1;
        if (is_write) begin
          next_we_n = 1'b0; // write strobe with select
          next_oe_n = 1'b1;
          next_bus_oe = 1'b1; // memory floats, host drives
        end else begin
          next_oe_n = 1'b0; // memory drives only in reads
        end
        cnt_load = 1'b1;
        // strobe and select held the slow-grade time
        cnt_value = is_write ? CNT_W'(WRITE_PULSE_CYC)
                             : CNT_W'(READ_WAIT_CYC);
        next_state = ASR_ACTIVE;
      end
      ASR_ACTIVE: begin
        if (cnt_done) begin
          if (is_write) begin
            next_we_n = 1'b1; // data held past end of write
          end else begin
            next_rdata = shared_data_bus_in; // sampled after access time
            next_rvalid = 1'b1;
            next_oe_n = 1'b1;
          end
          next_sel_n = 1'b1;
          next_sel_h = 1'b0;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(RECOVERY_CYC);
          next_state = ASR_RECOVER;
        end
      end
      ASR_RECOVER: begin
        // address and data unchanged through recovery
        if (cnt_done) begin
          next_bus_oe = 1'b0;
          cnt_load = 1'b1;
          cnt_value = CNT_W'(TURN_CYC);
          next_state = ASR_TURN;
        end
      end
      ASR_TURN: begin
        // memory float time passes before next cycle
        if (cnt_done) begin
          next_state = ASR_IDLE;
        end
      end
      ASR_RETAIN: begin
        if (!retain_req_in) begin
          cnt_load = 1'b1;
          cnt_value = CNT_W'(RETAIN_WAIT_CYC);
          next_state = ASR_WAKE;
        end
      end
      ASR_WAKE: begin
        // one read cycle after supply recovers
        if (cnt_done) begin
          next_state = ASR_IDLE;
        end
      end
      default: begin
        next_state = ASR_IDLE;
      end
    endcase
  end

  // contents are never reset; only pins and state are
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ASR_IDLE;
      is_write <= 1'b0;
      addr <= '0;
      wdata <= '0;
      rdata <= '0;
      rvalid <= 1'b0;
      sel_n <= 1'b1;
      sel_h <= 1'b0;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      bus_oe <= 1'b0;
    end else begin
      state <= next_state;
      is_write <= next_is_write;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      sel_n <= next_sel_n;
      sel_h <= next_sel_h;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      bus_oe <= next_bus_oe;
    end
  end

  // handshake is combinational; pins come from flip-flops
  assign req_ready_out = (state == ASR_IDLE) && !retain_req_in;
  assign retained_out = (state == ASR_RETAIN);
  assign rd_valid_out = rvalid;
  assign rd_data_out = rdata;
  assign word_address_out = addr; // 17-bit word address
  assign select_active_low_n_out = sel_n;
  assign select_active_high_out = sel_h;
  assign write_strobe_n_out = we_n;
  assign drive_enable_n_out = oe_n;
  assign shared_data_bus_out = wdata;
  assign shared_data_bus_oe_out = bus_oe;
endmodule : asr_host

// File: testbench/asr_host_checker.sv
// Purpose: pin checks on the memory host
// Assumes: one clock, async high reset
// Notes: sees top ports only
`timescale 1ns/1ps
module asr_host_checker #(
  parameter int ADDR_WIDTH = 17
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [ADDR_WIDTH-1:0] word_address_out,
  input wire logic select_active_low_n_out,
  input wire logic select_active_high_out,
  input wire logic write_strobe_n_out,
  input wire logic drive_enable_n_out,
  input wire logic shared_data_bus_oe_out,
  input wire logic rd_valid_out,
  input wire logic retained_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // short names for pin states
  wire sel = !select_active_low_n_out && select_active_high_out;
  wire wr = !write_strobe_n_out;
  wire rd = sel && !drive_enable_n_out && !wr;
  wire hoe = shared_data_bus_oe_out;
  a_sel_in_wr: assert property (wr |-> sel)
    else $error("strobe low while deselected");
  a_data_in_wr: assert property (wr |-> hoe)
    else $error("no write data under strobe");
  a_data_hold: assert property ($rose(write_strobe_n_out) |-> hoe)
    else $error("write data dropped at strobe end");
  a_addr_wr: assert property (wr |=> $stable(word_address_out))
    else $error("address moved around write");
  a_addr_high: assert property (
    select_active_high_out |=> $stable(word_address_out))
    else $error("address moved after high select");
  a_sel_width: assert property (
    $fell(select_active_low_n_out) |=> !select_active_low_n_out)
    else $error("selection too short");
  a_no_clash: assert property (!(rd && hoe))
    else $error("host drives during read");
  a_read_wait: assert property (
    rd_valid_out |-> $past(rd) && $past(rd, 2))
    else $error("read data taken too early");
  a_retain_desel: assert property (retained_out |-> !sel)
    else $error("selected in retention");
  a_wake_wait: assert property ($fell(retained_out) |-> !sel [*2])
    else $error("access too soon after wake");
endmodule : asr_host_checker

// File: testbench/asr_sram_model.sv
// Purpose: behavioural 128k x 8 static memory
// Assumes: pins come from the host under test
// Notes: a floating bus shows its last level inverted
`timescale 1ns/1ps
module asr_sram_model #(
  parameter int ACC_NS = 85
) (
  input wire logic [16:0] addr_in,
  input wire logic sel_n_in,
  input wire logic sel_h_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [7:0] hd_in,
  input wire logic hoe_in,
  output logic [7:0] bus_out
);
  // static array, no clock, no reset
  logic [7:0] mem [0:131071];
  logic [7:0] last = 8'h00;
  logic [7:0] rdata;
  wire sel = !sel_n_in && sel_h_in;
  // drives only in a read, floats at once
  wire drv = sel && we_n_in && !oe_n_in;
  // inertial delay keeps old data past an address change
  // unknown until one access time has passed
  assign #(ACC_NS) rdata = sel ? mem[addr_in] : 8'hxx;
  // store while selected and strobe low
  always @* begin
    if (sel && !we_n_in) begin
      mem[addr_in] = bus_out;
    end
  end
  // wire level from both parties' enables
  assign bus_out = (hoe_in && drv) ? 8'hxx :
    hoe_in ? hd_in : drv ? rdata : ~last;
  always @(bus_out) begin
    if (hoe_in || drv) begin
      last = bus_out;
    end
  end
endmodule : asr_sram_model

// File: testbench/asr_host_test.sv
// Purpose: self-checking bench for the memory host
// Assumes: inputs move 1 ns after the rising edge
// Notes: memory model uses the slow access time
`timescale 1ns/1ps
module asr_host_test;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic req_write_in = 1'b0;
  logic [16:0] req_addr_in = 17'h00000;
  logic [7:0] req_wdata_in = 8'h00;
  logic retain_req_in = 1'b0;
  logic req_ready_out, rd_valid_out, retained_out;
  logic [7:0] rd_data_out, shared_data_bus_in, shared_data_bus_out;
  logic [16:0] word_address_out;
  logic select_active_low_n_out, select_active_high_out;
  logic write_strobe_n_out, drive_enable_n_out, shared_data_bus_oe_out;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  asr_host DUT (.clk_in, .sys_rst_in, .req_valid_in, .req_write_in,
    .req_addr_in, .req_wdata_in, .retain_req_in, .req_ready_out,
    .rd_valid_out, .rd_data_out, .retained_out, .word_address_out,
    .select_active_low_n_out, .select_active_high_out,
    .write_strobe_n_out, .drive_enable_n_out, .shared_data_bus_in,
    .shared_data_bus_out, .shared_data_bus_oe_out);
  asr_sram_model #(.ACC_NS(85)) u_mem (.addr_in(word_address_out),
    .sel_n_in(select_active_low_n_out), .sel_h_in(select_active_high_out),
    .we_n_in(write_strobe_n_out), .oe_n_in(drive_enable_n_out),
    .hd_in(shared_data_bus_out), .hoe_in(shared_data_bus_oe_out),
    .bus_out(shared_data_bus_in));
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask : chk_bit
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step
  // bounded wait for the idle state
  task automatic wait_ready();
    for (int n = 0; n < 40 && req_ready_out !== 1'b1; n++) step();
  endtask : wait_ready
  task automatic send(input logic w, input logic [16:0] a,
                      input logic [7:0] d);
    wait_ready();
    req_valid_in = 1'b1;
    req_write_in = w;
    req_addr_in = a;
    req_wdata_in = d;
    step();
    req_valid_in = 1'b0;
  endtask : send
  task automatic rd(input logic [16:0] a, input logic [7:0] exp);
    send(1'b0, a, 8'h00);
    for (int n = 0; n < 20 && rd_valid_out !== 1'b1; n++) step();
    chk_bit(rd_valid_out, 1'b1);
    chk_byte(rd_data_out, exp);
  endtask : rd
  // back-to-back writes at both address extremes and two alternating patterns, then read back
  task automatic t_fill();
    logic [16:0] a [4] = '{17'h00000, 17'h1ffff, 17'h0aaaa, 17'h15555};
    logic [7:0] d [4] = '{8'h5a, 8'ha5, 8'h00, 8'hff};
    for (int i = 0; i < 4; i++) send(1'b1, a[i], d[i]);
    for (int i = 0; i < 4; i++) rd(a[i], d[i]);
    $display("test fill done");
  endtask : t_fill
  // retention deselects, data survives the wake
  task automatic t_retain();
    wait_ready();
    retain_req_in = 1'b1;
    step();
    chk_bit(retained_out, 1'b1);
    chk_bit(select_active_low_n_out, 1'b1);
    chk_bit(req_ready_out, 1'b0);
    repeat (3) step();
    retain_req_in = 1'b0;
    rd(17'h1ffff, 8'ha5);
    $display("test retain done");
  endtask : t_retain
  // reset lands in mid-write; other words must stay intact
  task automatic t_mid_reset();
    send(1'b1, 17'h00002, 8'h3c);
    step();
    step();
    chk_bit(write_strobe_n_out, 1'b0);
    chk_bit(select_active_high_out, 1'b1);
    chk_bit(drive_enable_n_out, 1'b1);
    chk_bit(shared_data_bus_oe_out, 1'b1);
    chk_byte(shared_data_bus_out, 8'h3c);
    chk_byte(word_address_out[7:0], 8'h02);
    sys_rst_in = 1'b1;
    step();
    step();
    sys_rst_in = 1'b0;
    // pins idle straight out of reset, first request may follow at once
    chk_bit(select_active_high_out, 1'b0);
    chk_bit(select_active_low_n_out, 1'b1);
    chk_bit(write_strobe_n_out, 1'b1);
    chk_bit(shared_data_bus_oe_out, 1'b0);
    chk_bit(req_ready_out, 1'b1);
    rd(17'h15555, 8'hff);
    $display("test mid reset done");
  endtask : t_mid_reset
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // hang guard, far beyond the hundred or so cycles needed
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_fill();
    t_retain();
    t_mid_reset();
    summarize();
  end
endmodule : asr_host_test
bind asr_host asr_host_checker #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
  .clk_in, .sys_rst_in, .word_address_out, .select_active_low_n_out,
  .select_active_high_out, .write_strobe_n_out, .drive_enable_n_out,
  .shared_data_bus_oe_out, .rd_valid_out, .retained_out);
